// ===== src/blcu_unit.sv
// Contract
// - load replaces result with operand bit
// - and combines result with operand bit
// - or combines result with operand bit
// - inverted variants use negated operand bit
// - immediate reads pin, input image untouched
// - immediate: on-board channels only, unfiltered
// - immediate load/and/or use fresh pin value
// - inverted immediate use negated fresh pin
// - write copies result into output image
// - write_inverted stores complemented result
// - bit_off clears output bit when result set
// - bit_on sets output bit when result set
// - coil operations never change the result
// - network end marker touches no storage
// - result updated after every executed contact, bar an out-of-range immediate
`timescale 1ns/1ps
`default_nettype none
`include "blcu_defs.svh"

module blcu_unit
    import blcu_pkg::*;
#(
    parameter int DEPTH = `BLCU_IMG_DEPTH,
    parameter int AW = `BLCU_ADDR_W,
    parameter int DI_N = `BLCU_DI_CHANNELS,
    parameter int DW = `BLCU_DI_W,
    parameter int FILT = `BLCU_FILTER_LEN
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset, active high
    input wire logic op_valid, // sequencer presents an operation
    input wire logic [4:0] op_code, // operation code
    input wire logic [AW-1:0] op_addr, // resolved operand bit address
    output logic op_ready, // unit idle, may take operation
    output logic op_done, // one-cycle completion pulse
    output logic op_error, // one-cycle: channel out of range
    output logic result, // current_result bit
    input wire logic [DI_N-1:0] di_pins, // on-board digital inputs
    input wire logic scan_in_we, // scan writes input image
    input wire logic [AW-1:0] scan_in_addr, // input image bit address
    output logic [DI_N-1:0] di_filtered, // filtered inputs for the scan
    input wire logic scan_rd_en, // scan reads output image
    input wire logic [AW-1:0] scan_rd_addr, // output image read address
    output logic scan_rd_data // output image read data
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // held operation and its progress
    blcu_state_e state_reg;
    blcu_op_e op_reg;
    logic [AW-1:0] addr_reg;
    logic result_reg;
    logic result_next;
    // datapath nets
    logic in_rd, out_rd, out_we, out_wd;
    logic out_rd_en;
    logic [AW-1:0] out_rd_addr;
    logic cur_op_is_now, cur_op_is_std, cur_op_is_coil;
    logic operand, operand_eff;
    logic pin_val;
    logic chan_ok;
    // filter delay line, scan path only
    logic [DI_N-1:0] filt_reg [FILT];

    // operation classes, decoded from the held code
    assign cur_op_is_std = (op_reg inside {BLCU_OP_LOAD, BLCU_OP_AND,
        BLCU_OP_OR, BLCU_OP_LOAD_INV, BLCU_OP_AND_INV, BLCU_OP_OR_INV});
    assign cur_op_is_now = (op_reg inside {BLCU_OP_LOAD_NOW,
        BLCU_OP_AND_NOW, BLCU_OP_OR_NOW, BLCU_OP_LOAD_INV_NOW,
        BLCU_OP_AND_INV_NOW, BLCU_OP_OR_INV_NOW});
    assign cur_op_is_coil = (op_reg inside {BLCU_OP_BIT_OFF,
        BLCU_OP_BIT_ON});

    // only channels present on the body are legal
    assign chan_ok = (addr_reg < AW'(DI_N));

    // ----------------------------------------------------------------
    // image memories
    // ----------------------------------------------------------------
    // input image is written only by the scan, never by a contact
    blcu_bit_mem #(.DEPTH(DEPTH), .AW(AW)) u_in_img (
        .clk_sys(clk_sys),
        .rd_en(state_reg == BLCU_STATE_READ),
        .rd_addr(addr_reg),
        .rd_data(in_rd),
        .wr_en(scan_in_we),
        .wr_addr(scan_in_addr),
        .wr_data(filt_reg[FILT-1][scan_in_addr[DW-1:0]])
    );

    // the output image read port is shared: the unit wins in its read cycle only
    assign out_rd_en = (state_reg == BLCU_STATE_READ) | scan_rd_en;
    assign out_rd_addr = (state_reg == BLCU_STATE_READ) ? addr_reg
        : scan_rd_addr;

    blcu_bit_mem #(.DEPTH(DEPTH), .AW(AW)) u_out_img (
        .clk_sys(clk_sys),
        .rd_en(out_rd_en),
        .rd_addr(out_rd_addr),
        .rd_data(out_rd),
        .wr_en(out_we),
        .wr_addr(addr_reg),
        .wr_data(out_wd)
    );

    // ----------------------------------------------------------------
    // input filter for the scan path
    // ----------------------------------------------------------------
    // immediate contacts tap the pins ahead of this delay line
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < FILT; i++) begin
                filt_reg[i] <= '0;
            end
        end else begin
            filt_reg[0] <= di_pins;
            for (int i = 1; i < FILT; i++) begin
                filt_reg[i] <= filt_reg[i-1];
            end
        end
    end

    // registered copy handed to the scan: one stage more than the line
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            di_filtered <= '0;
        end else begin
            di_filtered <= filt_reg[FILT-1];
        end
    end

    // ----------------------------------------------------------------
    // operand selection
    // ----------------------------------------------------------------
    // raw pin, sampled in the execute cycle, not the filtered copy
    assign pin_val = di_pins[addr_reg[DW-1:0]];

    // inverted contact forms negate whichever operand was chosen
    always_comb begin
        operand = cur_op_is_now ? pin_val : in_rd;
        case (op_reg)
            BLCU_OP_LOAD_INV, BLCU_OP_AND_INV, BLCU_OP_OR_INV: begin
                operand_eff = ~operand;
            end
            BLCU_OP_LOAD_INV_NOW, BLCU_OP_AND_INV_NOW,
            BLCU_OP_OR_INV_NOW: begin
                operand_eff = ~operand;
            end
            default: begin
                operand_eff = operand;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // coil write path
    // ----------------------------------------------------------------
    // plain writes always land; set and clear only while result is 1
    always_comb begin
        out_we = 1'b0;
        out_wd = 1'b0;
        if (state_reg == BLCU_STATE_EXEC) begin
            case (op_reg)
                BLCU_OP_WRITE: begin
                    out_we = 1'b1;
                    out_wd = result_reg;
                end
                BLCU_OP_WRITE_INV: begin
                    out_we = 1'b1;
                    out_wd = ~result_reg;
                end
                BLCU_OP_BIT_OFF: begin
                    out_we = result_reg & cur_op_is_coil;
                    out_wd = 1'b0;
                end
                BLCU_OP_BIT_ON: begin
                    out_we = result_reg & cur_op_is_coil;
                    out_wd = 1'b1;
                end
                default: begin
                    out_we = 1'b0;
                    out_wd = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    // one operation at a time; ready low while busy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= BLCU_STATE_IDLE;
            op_reg <= BLCU_OP_NOP;
            addr_reg <= '0;
        end else begin
            case (state_reg)
                BLCU_STATE_IDLE: begin
                    if (op_valid) begin
                        op_reg <= blcu_op_e'(op_code);
                        addr_reg <= op_addr;
                        state_reg <= BLCU_STATE_READ;
                    end
                end
                BLCU_STATE_READ: begin
                    state_reg <= BLCU_STATE_EXEC;
                end
                BLCU_STATE_EXEC: begin
                    state_reg <= BLCU_STATE_IDLE;
                end
                default: begin
                    state_reg <= BLCU_STATE_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // current result
    // ----------------------------------------------------------------
    // updated at the end of execute so the next operation sees it;
    // a bad immediate channel leaves the result as it was
    always_comb begin
        result_next = result_reg;
        if (state_reg == BLCU_STATE_EXEC &&
            (cur_op_is_std || (cur_op_is_now && chan_ok))) begin
            case (op_reg)
                BLCU_OP_LOAD, BLCU_OP_LOAD_INV: begin
                    result_next = operand_eff;
                end
                BLCU_OP_AND, BLCU_OP_AND_INV: begin
                    result_next = result_reg & operand_eff;
                end
                BLCU_OP_OR, BLCU_OP_OR_INV: begin
                    result_next = result_reg | operand_eff;
                end
                BLCU_OP_LOAD_NOW, BLCU_OP_LOAD_INV_NOW: begin
                    result_next = operand_eff;
                end
                BLCU_OP_AND_NOW, BLCU_OP_AND_INV_NOW: begin
                    result_next = result_reg & operand_eff;
                end
                BLCU_OP_OR_NOW, BLCU_OP_OR_INV_NOW: begin
                    result_next = result_reg | operand_eff;
                end
                default: begin
                    result_next = result_reg;
                end
            endcase
        end
        // coils and the end marker fall through untouched
    end

    // ----------------------------------------------------------------
    // result register
    // ----------------------------------------------------------------
    // the port takes the same next value, so it turns together with done
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_reg <= `BLCU_RESULT_RST;
        end else begin
            result_reg <= result_next;
        end
    end

    // ----------------------------------------------------------------
    // handshake outputs
    // ----------------------------------------------------------------
    // ready rises as the unit returns to idle; it stays low in reset
    // so no request is invited before the first edge after release
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_done <= 1'b0;
            op_error <= 1'b0;
            op_ready <= 1'b0;
            result <= `BLCU_RESULT_RST;
        end else begin
            op_done <= (state_reg == BLCU_STATE_EXEC);
            op_error <= (state_reg == BLCU_STATE_EXEC) && cur_op_is_now &&
                        !chan_ok;
            op_ready <= (state_reg == BLCU_STATE_EXEC) ||
                        (state_reg == BLCU_STATE_IDLE && !op_valid);
            result <= result_next;
        end
    end

    // scan read data pass straight from the memory register
    assign scan_rd_data = out_rd;

endmodule
`default_nettype wire

// ===== src/blcu_defs.svh
`ifndef BLCU_DEFS_SVH
`define BLCU_DEFS_SVH

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define BLCU_IMG_DEPTH 256
`define BLCU_ADDR_W 8
`define BLCU_DI_CHANNELS 16
`define BLCU_DI_W 4
`define BLCU_RESULT_RST 1'b0
`define BLCU_FILTER_LEN 4

`endif

// ===== src/blcu_pkg.sv
package blcu_pkg;

    // operation codes presented by the sequencer
    typedef enum logic [4:0] {
        BLCU_OP_NOP,
        BLCU_OP_LOAD,
        BLCU_OP_AND,
        BLCU_OP_OR,
        BLCU_OP_LOAD_INV,
        BLCU_OP_AND_INV,
        BLCU_OP_OR_INV,
        BLCU_OP_LOAD_NOW,
        BLCU_OP_AND_NOW,
        BLCU_OP_OR_NOW,
        BLCU_OP_LOAD_INV_NOW,
        BLCU_OP_AND_INV_NOW,
        BLCU_OP_OR_INV_NOW,
        BLCU_OP_WRITE,
        BLCU_OP_WRITE_INV,
        BLCU_OP_BIT_OFF,
        BLCU_OP_BIT_ON,
        BLCU_OP_NET_END
    } blcu_op_e;

    typedef enum {
        BLCU_STATE_IDLE,
        BLCU_STATE_READ,
        BLCU_STATE_EXEC
    } blcu_state_e;

endpackage

// ===== src/blcu_bit_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "blcu_defs.svh"

// one-bit-wide image memory, registered read, one write port
module blcu_bit_mem #(
    parameter int DEPTH = `BLCU_IMG_DEPTH,
    parameter int AW = `BLCU_ADDR_W
) (
    input wire logic clk_sys, // system clock
    input wire logic rd_en, // read strobe
    input wire logic [AW-1:0] rd_addr, // read address
    output logic rd_data, // registered read data
    input wire logic wr_en, // write strobe
    input wire logic [AW-1:0] wr_addr, // write address
    input wire logic wr_data // write data
);

    logic mem_reg [DEPTH];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // no reset on contents: the input image is filled by the scan, the output image by coil writes
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // read out of a register
    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem_reg[rd_addr];
        end
    end

endmodule
`default_nettype wire

// ===== testbench/blcu_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module blcu_unit_sva
    import blcu_pkg::*;
#(
    parameter int AW = 8,
    parameter int DI_N = 16
) (
    input wire logic clk_sys, // clock
    input wire logic rst, // sync reset
    input wire logic op_valid, // request
    input wire logic [4:0] op_code, // opcode
    input wire logic [AW-1:0] op_addr, // operand address
    input wire logic op_ready, // idle
    input wire logic op_done, // completion pulse
    input wire logic op_error, // bad channel pulse
    input wire logic result, // current result
    input wire logic [DI_N-1:0] di_pins // raw pins
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic take;
    logic now_op;
    logic inv;
    logic pin;
    logic [4:0] code_reg;
    logic [AW-1:0] addr_reg;
    logic [DI_N-1:0] pins_reg;
    assign take = op_valid && op_ready;
    assign now_op = code_reg inside {[5'd7:5'd12]};
    assign inv = code_reg inside {[5'd10:5'd12]};
    assign pin = pins_reg[addr_reg[3:0]] ^ inv;
    // remember the op, its outcome shows three edges later
    always_ff @(posedge clk_sys) begin
        if (take) begin
            code_reg <= op_code;
            addr_reg <= op_addr;
        end
    end
    // pins as seen during the execute cycle
    always_ff @(posedge clk_sys) begin
        pins_reg <= di_pins;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_latency; take |-> ##3 op_done; endproperty
    a_latency: assert property (p_latency)
        else $error("done late");
    property p_cause; op_done |-> $past(take, 3); endproperty
    a_cause: assert property (p_cause)
        else $error("done without op");
    property p_busy; take |=> !op_ready [*2]; endproperty
    a_busy: assert property (p_busy)
        else $error("ready while busy");
    property p_err; take && op_code inside {[5'd7:5'd12]} &&
        op_addr >= DI_N |-> ##3 op_error; endproperty
    a_err: assert property (p_err)
        else $error("bad channel accepted");
    property p_err_only; op_error |-> op_done && now_op &&
        addr_reg >= DI_N && $stable(result); endproperty
    a_err_only: assert property (p_err_only)
        else $error("spurious error");
    property p_keep; op_done && (code_reg >= 5'd13 || code_reg == 5'd0)
        |-> $stable(result); endproperty
    a_keep: assert property (p_keep)
        else $error("coil changed result");
    property p_load_now; op_done && !op_error &&
        code_reg inside {5'd7, 5'd10} |-> result == pin; endproperty
    a_load_now: assert property (p_load_now)
        else $error("immediate load wrong");
    property p_and_now; op_done && !op_error &&
        code_reg inside {5'd8, 5'd11} |-> result == ($past(result) & pin);
    endproperty
    a_and_now: assert property (p_and_now)
        else $error("immediate and wrong");
    property p_or_now; op_done && !op_error &&
        code_reg inside {5'd9, 5'd12} |-> result == ($past(result) | pin);
    endproperty
    a_or_now: assert property (p_or_now)
        else $error("immediate or wrong");
    c_load: cover property (take && op_code == 5'd1);
    c_err: cover property (op_error);
    c_set: cover property (take && op_code == 5'd16);
endmodule
`default_nettype wire

// ===== testbench/blcu_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// sequencer side: one op at a time, driven off the falling edge
module blcu_seq_model (
    input wire logic clk_sys, // clock
    input wire logic op_ready, // unit idle
    input wire logic op_done, // completion
    output logic op_valid, // request
    output logic [4:0] op_code, // opcode
    output logic [7:0] op_addr // operand address
);
    initial begin
        op_valid = 1'b0;
        op_code = 5'h00;
        op_addr = 8'h00;
    end
    // waits for idle, presents, then waits for the done pulse
    task automatic run(input logic [4:0] c, input logic [7:0] a,
                       output logic ok);
        int n;
        ok = 1'b0;
        n = 0;
        while (op_ready !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        // a unit that never turns ready is reported, not driven
        if (op_ready === 1'b1) begin
            op_code = c;
            op_addr = a;
            op_valid = 1'b1;
            @(negedge clk_sys);
            op_valid = 1'b0;
            n = 0;
            while (op_done !== 1'b1 && n < 8) begin
                @(negedge clk_sys);
                n++;
            end
            ok = (op_done === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// ===== testbench/blcu_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module blcu_unit_tb import blcu_pkg::*;;
    logic clk_sys, rst, op_valid, op_ready, op_done, op_error, result;
    logic scan_in_we, scan_rd_en, scan_rd_data, ok, res_want, b, got;
    logic [4:0] op_code;
    logic [7:0] op_addr, scan_in_addr, scan_rd_addr;
    logic [15:0] di_pins, di_filtered;
    int n_errors, checked;
    blcu_op_e coils[6] = '{BLCU_OP_WRITE, BLCU_OP_WRITE_INV,
        BLCU_OP_BIT_OFF, BLCU_OP_BIT_ON, BLCU_OP_NET_END, BLCU_OP_NOP};
    blcu_unit dut (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .op_addr(op_addr), .op_ready(op_ready),
        .op_done(op_done), .op_error(op_error), .result(result),
        .di_pins(di_pins), .scan_in_we(scan_in_we),
        .scan_in_addr(scan_in_addr), .di_filtered(di_filtered),
        .scan_rd_en(scan_rd_en), .scan_rd_addr(scan_rd_addr),
        .scan_rd_data(scan_rd_data));
    blcu_seq_model seq (.clk_sys(clk_sys), .op_ready(op_ready),
        .op_done(op_done), .op_valid(op_valid), .op_code(op_code),
        .op_addr(op_addr));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic test_done();
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %b got %b", what, e, g);
        end
    endtask
    task automatic do_op(input blcu_op_e c, input logic [7:0] a);
        seq.run(c, a, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch op_done exp 1 got 0");
            test_done();
        end
    endtask
    // image bit 0x20 holds 1, 0x21 holds 0
    task automatic set_result(input logic v);
        do_op(BLCU_OP_LOAD, v ? 8'h20 : 8'h21);
        chk("load", v, result);
    endtask
    // contact ops 1..12: load/and/or, plain then inverted, twice
    function automatic logic f_ref(int c, logic r, logic v);
        logic o;
        o = v ^ (((c - 1) / 3) % 2 == 1);
        if ((c - 1) % 3 == 0) return o;
        if ((c - 1) % 3 == 1) return r & o;
        return r | o;
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_contacts();
        di_pins = 16'h0001;
        repeat (4) @(negedge clk_sys);
        chk("filter early", 1'b0, di_filtered[0]);
        repeat (4) @(negedge clk_sys);
        checked++;
        if (di_filtered !== 16'h0001) begin
            n_errors++;
            $display("mismatch di_filtered exp %h got %h", 16'h0001,
                di_filtered);
        end
        scan_in_we = 1'b1;
        scan_in_addr = 8'h20;
        @(negedge clk_sys);
        scan_in_addr = 8'h21;
        @(negedge clk_sys);
        scan_in_addr = 8'h05;
        @(negedge clk_sys);
        scan_in_we = 1'b0;
        for (int i = 1; i <= 6; i++) begin
            for (int j = 0; j < 4; j++) begin
                set_result(j[1]);
                do_op(blcu_op_e'(i), j[0] ? 8'h20 : 8'h21);
                chk("contact", f_ref(i, j[1], j[0]), result);
            end
        end
    endtask
    // pin flips just before the op, so a filtered value would be stale
    task automatic t_now();
        for (int i = 7; i <= 12; i++) begin
            for (int j = 0; j < 4; j++) begin
                di_pins = j[0] ? 16'h0000 : 16'h0020;
                set_result(j[1]);
                repeat (8) @(negedge clk_sys);
                di_pins = j[0] ? 16'h0020 : 16'h0000;
                do_op(blcu_op_e'(i), 8'h05);
                chk("immediate", f_ref(i, j[1], j[0]), result);
            end
        end
        do_op(BLCU_OP_LOAD, 8'h05);
        chk("input image", 1'b0, result);
        do_op(BLCU_OP_LOAD_INV_NOW, 8'h10);
        chk("op_error", 1'b1, op_error);
        chk("result", 1'b0, result);
    endtask
    task automatic t_coils();
        for (int i = 0; i < 6; i++) begin
            for (int j = 0; j < 4; j++) begin
                res_want = j[1];
                b = j[0];
                set_result(b);
                do_op(BLCU_OP_WRITE, 8'h40);
                set_result(res_want);
                do_op(coils[i], 8'h40);
                chk("result kept", res_want, result);
                scan_rd_en = 1'b1;
                scan_rd_addr = 8'h40;
                @(negedge clk_sys);
                got = scan_rd_data;
                scan_rd_en = 1'b0;
                case (coils[i])
                    BLCU_OP_WRITE: b = res_want;
                    BLCU_OP_WRITE_INV: b = !res_want;
                    BLCU_OP_BIT_OFF: b = b & !res_want;
                    BLCU_OP_BIT_ON: b = b | res_want;
                    default: b = b;
                endcase
                chk("output image", b, got);
            end
        end
    endtask
    initial begin
        rst = 1'b1;
        di_pins = 16'h0000;
        scan_in_we = 1'b0;
        scan_in_addr = 8'h00;
        scan_rd_en = 1'b0;
        scan_rd_addr = 8'h00;
        n_errors = 0;
        checked = 0;
        repeat (10) @(negedge clk_sys);
        chk("reset result", 1'b0, result);
        chk("reset ready", 1'b0, op_ready);
        rst = 1'b0;
        @(negedge clk_sys);
        t_contacts();
        t_now();
        t_coils();
        test_done();
    end
endmodule
bind blcu_unit blcu_unit_sva #(.AW(AW), .DI_N(DI_N)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_ready(op_ready),
    .op_done(op_done), .op_error(op_error), .result(result),
    .di_pins(di_pins));
`default_nettype wire
